// *** hw/epx_config_regs.v ***
// epx_config_regs.v: extra configuration registers (release number,
// frame length adjust, port wake mask) with the micro-frame counter.
// assumes a byte-wide configuration access port, synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "epx_consts.vh"

module epx_config_regs #(
    parameter FIELD_W = 6
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        cfg_sel,
    input  wire        cfg_wr,
    input  wire [7:0]  cfg_addr,
    input  wire [7:0]  cfg_wdata,
    input  wire        sof_tick_en,
    output reg  [7:0]  cfg_rdata,
    output reg         cfg_hit,
    output reg  [15:0] port_wake_capability_mask,
    output reg  [7:0]  frame_length_adjust,
    output reg         sof_pulse
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    wire        sof_pulse_i;
    wire [15:0] sof_count;
    wire [15:0] sof_period;

    // the reserved bits are stored as written; software keeps them zero
    wire wr_frame = cfg_sel & cfg_wr & (cfg_addr == `EPX_OFS_FRAME_LEN);
    wire wr_wlo   = cfg_sel & cfg_wr & (cfg_addr == `EPX_OFS_WAKE_LO);
    wire wr_whi   = cfg_sel & cfg_wr & (cfg_addr == `EPX_OFS_WAKE_HI);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_length_adjust       <= {2'b00, `EPX_FRAME_LEN_RST};
            port_wake_capability_mask <= `EPX_WAKE_RST;
        end else begin
            if (wr_frame)
                frame_length_adjust <= cfg_wdata;
            // mask is storage only, wired to nothing else
            if (wr_wlo)
                port_wake_capability_mask[7:0] <= cfg_wdata;
            if (wr_whi)
                port_wake_capability_mask[15:8] <= cfg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // read path; unmapped offsets read zero with no hit
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
            cfg_hit   <= 1'b0;
        end else begin
            cfg_hit <= 1'b0;
            if (cfg_sel && !cfg_wr) begin
                cfg_hit <= 1'b1;
                if (cfg_addr == `EPX_OFS_RELEASE)
                    cfg_rdata <= `EPX_RELEASE_VALUE;
                else if (cfg_addr == `EPX_OFS_FRAME_LEN)
                    cfg_rdata <= frame_length_adjust;
                else if (cfg_addr == `EPX_OFS_WAKE_LO)
                    cfg_rdata <= port_wake_capability_mask[7:0];
                else if (cfg_addr == `EPX_OFS_WAKE_HI)
                    cfg_rdata <= port_wake_capability_mask[15:8];
                else begin
                    cfg_rdata <= 8'h00;
                    cfg_hit   <= 1'b0;
                end
            end else if (cfg_sel) begin
                cfg_hit <= (cfg_addr == `EPX_OFS_FRAME_LEN) | (cfg_addr == `EPX_OFS_WAKE_LO)
                         | (cfg_addr == `EPX_OFS_WAKE_HI) | (cfg_addr == `EPX_OFS_RELEASE);
            end
        end
    end

    // ------------------------------------------------------------------
    // micro-frame counter; one tick is one 480 MHz bit time
    // ------------------------------------------------------------------
    epx_sof_counter #(
        .FIELD_W    (FIELD_W)
    ) u_sof (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .tick_en    (sof_tick_en),
        .frame_len  (frame_length_adjust[`EPX_FRAME_LEN_MSB:0]),
        .sof_pulse  (sof_pulse_i),
        .sof_count  (sof_count),
        .sof_period (sof_period)
    );

    always @(posedge ref_clk) begin
        if (!rst_n)
            sof_pulse <= 1'b0;
        else
            sof_pulse <= sof_pulse_i;
    end
endmodule
`default_nettype wire

// *** hw/epx_consts.vh ***
// epx_consts.vh: offsets, reset values, field positions and timing counts
// for the extra configuration registers of the enhanced host controller.
// assumes byte addressing within the function's configuration space.
`ifndef EPX_CONSTS_VH
`define EPX_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses in configuration space)
// ----------------------------------------------------------------------
`define EPX_OFS_RELEASE     8'h60
`define EPX_OFS_FRAME_LEN   8'h61
`define EPX_OFS_WAKE_LO     8'h62
`define EPX_OFS_WAKE_HI     8'h63

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define EPX_RELEASE_VALUE   8'h20
`define EPX_FRAME_LEN_RST   6'h20
`define EPX_FRAME_LEN_MSB   5
`define EPX_WAKE_RST        16'h001f

// ----------------------------------------------------------------------
// sof period: base count plus field, one tick per step
// ----------------------------------------------------------------------
`define EPX_SOF_BASE        16'he860
`define EPX_SOF_WIDTH       16

`endif

// *** hw/epx_sof_counter.v ***
// epx_sof_counter.v: micro-frame counter whose period follows the frame
// length field. runs on the one clock; tick_en marks counter clocks.
`timescale 1ns/1ps
`default_nettype none
`include "epx_consts.vh"

module epx_sof_counter #(
    parameter FIELD_W = 6
) (
    input  wire               ref_clk,
    input  wire               rst_n,
    input  wire               tick_en,
    input  wire [FIELD_W-1:0] frame_len,
    output reg                sof_pulse,
    output reg  [15:0]        sof_count,
    output reg  [15:0]        sof_period
);
    // ------------------------------------------------------------------
    // period arithmetic
    // ------------------------------------------------------------------
    function [15:0] period_of;
        input [FIELD_W-1:0] f;
        begin
            period_of = `EPX_SOF_BASE + {{(16-FIELD_W){1'b0}}, f};
        end
    endfunction

    // ------------------------------------------------------------------
    // counter; new length taken only at the boundary so no frame is cut
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sof_count  <= 16'h0000;
            sof_period <= `EPX_SOF_BASE + {10'h000, `EPX_FRAME_LEN_RST};
            sof_pulse  <= 1'b0;
        end else begin
            sof_pulse <= 1'b0;
            if (tick_en) begin
                if (sof_count == sof_period - 16'h0001) begin
                    sof_count  <= 16'h0000;
                    sof_period <= period_of(frame_len);
                    sof_pulse  <= 1'b1;
                end else begin
                    sof_count <= sof_count + 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/epx_config_regs_props.sv ***
// checker: access, hit and reset properties of the extra config registers
// assumes binding into epx_config_regs, one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module epx_config_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        cfg_sel,
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [7:0]  cfg_wdata,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        cfg_hit,
    input wire logic [15:0] port_wake_capability_mask,
    input wire logic [7:0]  frame_length_adjust
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire        rd  = cfg_sel && !cfg_wr;
    wire [7:0]  wa  = (cfg_sel && cfg_wr) ? cfg_addr : 8'h00;
    wire        hit = cfg_sel && cfg_addr[7:2] == 6'h18;
    wire [7:0]  fla = frame_length_adjust;
    wire [15:0] msk = port_wake_capability_mask;
    AST_REL_RD:
        assert property (rd && cfg_addr == 8'h60 |=> cfg_rdata == 8'h20) else $error("rel");
    AST_FLA_WR:
        assert property (wa == 8'h61 |=> fla == $past(cfg_wdata)) else $error("fla");
    AST_WK_LO:
        assert property (wa == 8'h62 |=> msk[7:0] == $past(cfg_wdata)) else $error("lo");
    AST_WK_HI:
        assert property (wa == 8'h63 |=> msk[15:8] == $past(cfg_wdata)) else $error("hi");
    AST_HIT: assert property (hit |=> cfg_hit) else $error("hit");
    AST_NO_HIT: assert property (!hit |=> !cfg_hit) else $error("nohit");
    AST_RST:
        assert property ($rose(rst_n) |-> fla == 8'h20 && msk == 16'h001f) else $error("rst");
    AST_HOLD:
        assert property (wa[7:1] != 7'h31 |=> $stable(msk)) else $error("hold");
    C_REL: cover property (rd && cfg_addr == 8'h60);
    C_FLA: cover property (wa == 8'h61);
    C_WAKE: cover property (wa == 8'h63);
endmodule
bind epx_config_regs epx_config_props u_epx_config_props (.*);
`default_nettype wire

// *** testbench/tb_epx_config_regs.sv ***
// bench: reset values, read-only byte, random register traffic, frame period
// assumes design files and the bound checker are compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
module tb_epx_config_regs;
    logic        ref_clk = 1'b0, rst_n, cfg_sel, cfg_wr, sof_tick_en, cfg_hit, sof_pulse;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, frame_length_adjust, a, d;
    logic [7:0]  m [4] = '{8'h20, 8'h20, 8'h1f, 8'h00};
    logic [15:0] port_wake_capability_mask;
    int          err_count, compares, n, seed = 39133;
    epx_config_regs u_epx_config_regs (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    task chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) err_count++;
        if (s !== e) $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    endtask
    task report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task acc(input logic w, input logic [7:0] ad, input logic [7:0] dt);
        {cfg_sel, cfg_wr, cfg_addr, cfg_wdata} = {1'b1, w, ad, dt};
        @(negedge ref_clk);
        if (w && ad != 8'h60 && ad[7:2] == 6'h18) m[ad[1:0]] = dt;
        if (!w) chk(cfg_rdata, ad[7:2] == 6'h18 ? m[ad[1:0]] : 8'h00);
        chk({15'h0000, cfg_hit}, {15'h0000, ad[7:2] == 6'h18});
        chk(frame_length_adjust, m[1]);
        chk(port_wake_capability_mask, {m[3], m[2]});
    endtask
    initial begin
        {rst_n, cfg_sel, cfg_wr, cfg_addr, cfg_wdata, sof_tick_en} = 20'h0_0001;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        for (a = 8'h60; a < 8'h64; a++) acc(1'b0, a, 8'h00);
        acc(1'b1, 8'h60, 8'hff);
        acc(1'b1, 8'h62, 8'h0a);
        repeat (60) begin
            a = 8'h5e + 8'($random(seed) & 7);
            d = 8'($random(seed)) & (a == 8'h61 ? 8'h3f : 8'hff);
            acc(d[0], a, d);
        end
        acc(1'b1, 8'h61, 8'h00);
        cfg_sel = 1'b0;
        $display("test registers done");
        // tick held high, so a frame in ticks is a frame in cycles; a timeout fails the count
        repeat (2)
            for (n = 0; n == 0 || (!sof_pulse && n < 70000); n++) @(negedge ref_clk);
        chk(n[15:0], 16'he860 + {10'h000, m[1][5:0]});
        $display("test frame period done");
        report_and_stop;
    end
endmodule
`default_nettype wire
